// *** core/fpu_port_dev.sv ***
// fpu end of the operand-load and result-return port
// Overview of operation
// - operands load from A/B buses by format
// - valid command, then cycle 0, maybe 1
// - two doubles: high words, then low
// - single-cycle formats have no cycle 1
// - B bus is the second operand, or the low word of a one-long or one-double operand
// - busy low from next cycle to output
// - unit pushes results when done, unrequested
// - ignore commands busy, after busy, first out
// - result low word first, high second
// - kill ends transaction next cycle, idle
// - hold freezes and repeats current cycle
// - hold honoured always, kill overrides
// - command counts when valid and legal
// - pipeline stalls after op reading top
// - powerdown shuts the microcode roms
// - result one cycle after busy deasserts
// - idle keeps all state unchanged except the rom enable, which follows powerdown
`timescale 1ns/1ps
module fpu_port_dev
   import fpu_port_pkg::*;
(
   input wire logic clk, // core clock
   input wire logic reset_n, // synchronous reset, active low
   fpu_port_if.fpu port, // link to the pipeline
   output logic rom_enable // microcode roms powered
);
   // ************************************************************
   // state
   // ************************************************************
   port_state_e state_r, state_nxt;
   logic [7:0] cmd_r, cmd_nxt;
   logic [63:0] opa_r, opa_nxt;
   logic [63:0] opb_r, opb_nxt;
   logic [63:0] res_r, res_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic busy_n_r, busy_n_nxt;
   logic [31:0] out_r, out_nxt;
   logic rom_en_r, rom_en_nxt;
   logic [63:0] calc_res;
   logic take;

   fpu_calc_unit u_calc (
      .kind(cmd_r[6:4]),
      .opa(opa_r),
      .opb(opb_r),
      .res(calc_res)
   );

   // ************************************************************
   // command acceptance
   // ************************************************************
   // only plain idle accepts: busy, the cycle busy rises, the gap
   // after a one-word result and the first of two words all refuse
   always_comb begin
      take = 1'b0;
      if (port.op_valid && cmd_legal(port.op_cmd)) begin
         take = (state_r == ST_IDLE);
      end
   end

   // ************************************************************
   // control: state, cycle count, busy
   // ************************************************************
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      busy_n_nxt = busy_n_r;
      if (port.kill) begin
         state_nxt = ST_IDLE;
         busy_n_nxt = 1'b1;
      end else if (port.hold) begin
         state_nxt = state_r;
      end else begin
         unique case (state_r)
            ST_IDLE, ST_OUT1, ST_GAP: begin
               state_nxt = ST_IDLE;
               if (take) begin
                  state_nxt = ST_LOAD0;
                  busy_n_nxt = 1'b0;
               end
            end
            ST_LOAD0: begin
               cnt_nxt = CNT_RESET;
               state_nxt = fmt_two_cycle(cmd_r[2:0]) ? ST_LOAD1 : ST_CALC;
            end
            ST_LOAD1: begin
               state_nxt = ST_CALC;
            end
            ST_CALC: begin
               cnt_nxt = cnt_r + 4'h1;
               if (cnt_r == CALC_CYCLES - 4'h1) begin
                  busy_n_nxt = 1'b1;
                  state_nxt = ST_OUT0;
               end
            end
            ST_OUT0: begin
               // a one-word result still passes a refusing gap cycle
               state_nxt = cmd_r[OP_WIDE_BIT] ? ST_OUT1 : ST_GAP;
            end
         endcase
      end
      if (!reset_n) begin
         state_nxt = ST_IDLE;
         cnt_nxt = CNT_RESET;
         busy_n_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      busy_n_r <= busy_n_nxt;
   end

   // ************************************************************
   // datapath: command, operands, result
   // ************************************************************
   always_comb begin
      cmd_nxt = cmd_r;
      opa_nxt = opa_r;
      opb_nxt = opb_r;
      res_nxt = res_r;
      if (!port.kill && !port.hold) begin
         if (take) begin
            cmd_nxt = port.op_cmd;
         end
         if (state_r == ST_LOAD0) begin
            unique case (cmd_r[2:0])
               FMT_TWO_DOUBLES: begin
                  opa_nxt = {port.a_bus, WORD_RESET};
                  opb_nxt = {port.b_bus, WORD_RESET};
               end
               FMT_TWO_SINGLES: begin
                  opa_nxt = {WORD_RESET, port.a_bus};
                  opb_nxt = {WORD_RESET, port.b_bus};
               end
               FMT_ONE_LONG, FMT_ONE_DOUBLE: begin
                  opa_nxt = {port.a_bus, port.b_bus};
                  opb_nxt = {WORD_RESET, WORD_RESET};
               end
               default: begin
                  opa_nxt = {WORD_RESET, port.a_bus};
                  opb_nxt = {WORD_RESET, WORD_RESET};
               end
            endcase
         end
         if (state_r == ST_LOAD1) begin
            opa_nxt = {opa_r[63:32], port.a_bus};
            opb_nxt = {opb_r[63:32], port.b_bus};
         end
         if (state_r == ST_CALC && cnt_r == CALC_CYCLES - 4'h1) begin
            res_nxt = calc_res;
         end
      end
      if (!reset_n) begin
         cmd_nxt = 8'h00;
      end
   end

   always_ff @(posedge clk) begin
      cmd_r <= cmd_nxt;
      opa_r <= opa_nxt;
      opb_r <= opb_nxt;
      res_r <= res_nxt;
   end

   // ************************************************************
   // result words
   // ************************************************************
   always_comb begin
      out_nxt = out_r;
      if (!port.kill && !port.hold) begin
         if (state_r == ST_OUT0) begin
            out_nxt = res_r[31:0];
         end
         if (state_r == ST_OUT1) begin
            out_nxt = res_r[63:32];
         end
      end
      if (!reset_n) begin
         out_nxt = WORD_RESET;
      end
   end

   always_ff @(posedge clk) begin
      out_r <= out_nxt;
   end

   // ************************************************************
   // microcode rom power
   // ************************************************************
   always_comb begin
      rom_en_nxt = !port.powerdown;
      if (!reset_n) begin
         rom_en_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      rom_en_r <= rom_en_nxt;
   end

   assign port.busy_n = busy_n_r;
   assign port.result_bus = out_r;
   assign rom_enable = rom_en_r;
endmodule

// *** core/fpu_port_pkg.sv ***
// shared constants and types for the fpu operand/result port
package fpu_port_pkg;
   localparam int unsigned OP_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned FMT_W = 3;
   // load format codes carried on the command
   localparam logic [2:0] FMT_TWO_DOUBLES = 3'h0;
   localparam logic [2:0] FMT_TWO_SINGLES = 3'h1;
   localparam logic [2:0] FMT_ONE_LONG = 3'h2;
   localparam logic [2:0] FMT_ONE_DOUBLE = 3'h3;
   localparam logic [2:0] FMT_ONE_INT = 3'h4;
   localparam logic [2:0] FMT_ONE_SINGLE = 3'h5;
   // command byte layout: [7] result is two words, [6:4] op, [2:0] format
   localparam int unsigned OP_WIDE_BIT = 7;
   localparam int unsigned OP_KIND_LSB = 4;
   localparam logic [2:0] KIND_ADD = 3'h0;
   localparam logic [2:0] KIND_SUB = 3'h1;
   localparam logic [2:0] KIND_MOVE = 3'h2;
   localparam logic [7:0] CMD_DOUBLE_SUBTRACT = 8'h90;
   // compute latency of the stand-in datapath, in cycles
   localparam logic [3:0] CALC_CYCLES = 4'h4;
   localparam logic [3:0] CNT_RESET = 4'h0;
   localparam logic [31:0] WORD_RESET = 32'h0;

   typedef enum logic [3:0] {
      ST_IDLE, ST_LOAD0, ST_LOAD1, ST_CALC, ST_OUT0, ST_OUT1, ST_GAP
   } port_state_e;

   function automatic logic cmd_legal(input logic [7:0] op);
      cmd_legal = (op[2:0] <= FMT_ONE_SINGLE) && (op[3] == 1'b0)
         && (op[6:4] <= KIND_MOVE);
   endfunction

   function automatic logic fmt_two_cycle(input logic [2:0] fmt);
      fmt_two_cycle = (fmt == FMT_TWO_DOUBLES);
   endfunction
endpackage

// *** core/fpu_port_if.sv ***
// interface joining the pipeline end and the fpu end
`timescale 1ns/1ps
interface fpu_port_if;
   logic [7:0] op_cmd;
   logic op_valid;
   logic [31:0] a_bus;
   logic [31:0] b_bus;
   logic [31:0] result_bus;
   logic busy_n;
   logic kill;
   logic hold;
   logic powerdown;
   modport fpu (input op_cmd, op_valid, a_bus, b_bus, kill, hold, powerdown,
      output result_bus, busy_n);
   modport pipe (output op_cmd, op_valid, a_bus, b_bus, kill, hold,
      powerdown, input result_bus, busy_n);
endinterface

// *** core/fpu_calc_unit.sv ***
// stand-in 64-bit arithmetic for the fpu port (integer add/sub/move)
`timescale 1ns/1ps
module fpu_calc_unit
   import fpu_port_pkg::*;
(
   input wire logic [2:0] kind, // operation kind
   input wire logic [63:0] opa, // first operand
   input wire logic [63:0] opb, // second operand
   output logic [63:0] res // result
);
   always_comb begin
      unique case (kind)
         KIND_ADD: res = opa + opb;
         KIND_SUB: res = opa - opb;
         default: res = opa;
      endcase
   end
endmodule

// *** core/fpu_port_pipe.sv ***
// pipeline end: issues one command and collects its result
`timescale 1ns/1ps
module fpu_port_pipe
   import fpu_port_pkg::*;
(
   input wire logic clk, // core clock
   input wire logic reset_n, // synchronous reset, active low
   fpu_port_if.pipe port, // link to the fpu
   input wire logic req_valid, // user command request
   input wire logic [7:0] req_cmd, // user command byte
   input wire logic [63:0] req_a, // first operand
   input wire logic [63:0] req_b, // second operand
   input wire logic req_kill, // abort request
   input wire logic req_hold, // freeze request
   input wire logic req_pwrdn, // powerdown request
   output logic req_ready, // ready for a command
   output logic res_valid, // result pulse
   output logic [63:0] res_data, // result value
   output logic tos_stall // extra stall after an fpu op
);
   typedef enum logic [2:0] {P_IDLE, P_C0, P_C1, P_WAIT, P_R0, P_R1}
      pipe_state_e;
   pipe_state_e st_r, st_nxt;
   logic [7:0] cmd_r, cmd_nxt;
   logic [63:0] a_r, a_nxt, b_r, b_nxt, res_r, res_nxt;
   logic vld_r, vld_nxt, rv_r, rv_nxt, stall_r, stall_nxt;
   logic [31:0] ab_r, ab_nxt, bb_r, bb_nxt;
   logic kill_r, hold_r, pd_r;

   always_comb begin
      st_nxt = st_r;
      cmd_nxt = cmd_r;
      a_nxt = a_r;
      b_nxt = b_r;
      res_nxt = res_r;
      vld_nxt = 1'b0;
      rv_nxt = 1'b0;
      stall_nxt = 1'b0;
      ab_nxt = WORD_RESET;
      bb_nxt = WORD_RESET;
      // follow kill and hold as the fpu sees them, so both ends agree
      if (kill_r) begin
         st_nxt = P_IDLE;
      end else if (hold_r) begin
         vld_nxt = vld_r;
         ab_nxt = ab_r;
         bb_nxt = bb_r;
      end else begin
         unique case (st_r)
            P_IDLE: if (req_valid) begin
               cmd_nxt = req_cmd;
               a_nxt = req_a;
               b_nxt = req_b;
               vld_nxt = 1'b1;
               st_nxt = P_C0;
            end
            P_C0: begin
               unique case (cmd_r[2:0])
                  FMT_TWO_DOUBLES, FMT_ONE_LONG, FMT_ONE_DOUBLE: begin
                     ab_nxt = a_r[63:32];
                     bb_nxt = (cmd_r[2:0] == FMT_TWO_DOUBLES) ?
                        b_r[63:32] : a_r[31:0];
                  end
                  FMT_TWO_SINGLES: begin
                     ab_nxt = a_r[31:0];
                     bb_nxt = b_r[31:0];
                  end
                  default: ab_nxt = a_r[31:0];
               endcase
               st_nxt = fmt_two_cycle(cmd_r[2:0]) ? P_C1 : P_WAIT;
            end
            P_C1: begin
               ab_nxt = a_r[31:0];
               bb_nxt = b_r[31:0];
               st_nxt = P_WAIT;
            end
            P_WAIT: if (port.busy_n) st_nxt = P_R0;
            P_R0: begin
               res_nxt = {32'h0, port.result_bus};
               if (cmd_r[OP_WIDE_BIT]) begin
                  st_nxt = P_R1;
               end else begin
                  rv_nxt = 1'b1;
                  stall_nxt = 1'b1;
                  st_nxt = P_IDLE;
               end
            end
            P_R1: begin
               res_nxt = {port.result_bus, res_r[31:0]};
               rv_nxt = 1'b1;
               stall_nxt = 1'b1;
               st_nxt = P_IDLE;
            end
            default: st_nxt = P_IDLE;
         endcase
      end
      if (!reset_n) st_nxt = P_IDLE;
   end

   always_ff @(posedge clk) begin
      st_r <= st_nxt;
      cmd_r <= cmd_nxt;
      a_r <= a_nxt;
      b_r <= b_nxt;
      res_r <= res_nxt;
      vld_r <= reset_n && vld_nxt;
      rv_r <= reset_n && rv_nxt;
      stall_r <= reset_n && stall_nxt;
      ab_r <= ab_nxt;
      bb_r <= bb_nxt;
      kill_r <= reset_n && req_kill;
      hold_r <= reset_n && req_hold;
      pd_r <= reset_n && req_pwrdn;
   end

   assign port.op_cmd = cmd_r;
   assign port.op_valid = vld_r;
   assign port.a_bus = ab_r;
   assign port.b_bus = bb_r;
   assign port.kill = kill_r;
   assign port.hold = hold_r;
   assign port.powerdown = pd_r;
   assign req_ready = (st_r == P_IDLE);
   assign res_valid = rv_r;
   assign res_data = res_r;
   assign tos_stall = stall_r;
endmodule

// *** tb/fpu_port_assertions.sv ***
// checker on the signals between the two ends of the fpu port
`timescale 1ns/1ps
module fpu_port_assertions
   import fpu_port_pkg::*;
(
   input wire logic clk, // core clock
   input wire logic reset_n, // sync reset, low
   input wire logic [7:0] op_cmd, // command byte
   input wire logic op_valid, // command valid
   input wire logic [31:0] result_bus, // result word
   input wire logic busy_n, // busy, low
   input wire logic kill, // abort
   input wire logic hold // freeze
);
   // ********
   // properties
   // ********
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   cmd_busy_a: assert property (
      op_valid && cmd_legal(op_cmd) && busy_n && $past(busy_n, 2)
      && !kill && !hold |=> !busy_n) else $error("busy not raised");
   hold_busy_a: assert property (
      hold && !kill |=> $stable(busy_n)) else $error("busy moved in hold");
   hold_res_a: assert property (
      hold && !kill |=> $stable(result_bus)) else $error("result moved");
   kill_idle_a: assert property (
      kill |-> ##[1:2] busy_n) else $error("kill not honoured");
   busy_bound_a: assert property (
      (!busy_n && !hold && !kill)[*8] |-> 1'b0) else $error("busy too long");
   valid_pulse_a: assert property (
      op_valid && !hold |=> !op_valid)
      else $error("valid longer than a cycle");
   no_cmd_busy_a: assert property (
      !busy_n |-> !op_valid) else $error("command while busy");
   idle_quiet_a: assert property (
      (busy_n && !op_valid)[*3] |=> $stable(result_bus))
      else $error("result toggles in idle");
   cover property ($rose(busy_n));
   cover property (hold && !busy_n);
   cover property (kill && !busy_n);
endmodule

// *** tb/testbench.sv ***
// self-checking bench joining both ends of the fpu port
`timescale 1ns/1ps
module testbench;
   import fpu_port_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic req_valid = 1'b0, req_kill = 1'b0, req_hold = 1'b0;
   logic req_pwrdn = 1'b0;
   logic [7:0] req_cmd = 8'h00;
   logic [63:0] req_a = 64'h0, req_b = 64'h0, res_data;
   logic req_ready, res_valid, tos_stall, rom_enable;
   logic b1 = 1'b1, b2 = 1'b1, got_ls = 1'b0;
   logic [31:0] ls;
   logic [63:0] exp_q[$], wire_q[$];
   int err_total = 0, num_checks = 0, cycles = 0, stalls = 0, ops = 0;
   always #5 clk = ~clk;
   fpu_port_if port();
   fpu_port_dev i_fpu_port_dev(.clk(clk), .reset_n(reset_n), .port(port),
      .rom_enable(rom_enable));
   fpu_port_pipe i_fpu_port_pipe(.clk(clk), .reset_n(reset_n), .port(port),
      .req_valid(req_valid), .req_cmd(req_cmd), .req_a(req_a), .req_b(req_b),
      .req_kill(req_kill), .req_hold(req_hold), .req_pwrdn(req_pwrdn),
      .req_ready(req_ready), .res_valid(res_valid), .res_data(res_data),
      .tos_stall(tos_stall));
   fpu_port_assertions chk(.clk(clk), .reset_n(reset_n),
      .op_cmd(port.op_cmd), .op_valid(port.op_valid),
      .result_bus(port.result_bus), .busy_n(port.busy_n), .kill(port.kill),
      .hold(port.hold));
   // ********
   // checking
   // ********
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles > 2000) begin
         err_total++;
         test_done();
      end
      b1 <= port.busy_n;
      b2 <= b1;
      if (tos_stall === 1'b1) stalls++;
      if (res_valid === 1'b1) begin
         ops++;
         if (exp_q.size() == 0) check({63'h0, res_valid}, 64'h0);
         else check(res_data, exp_q.pop_front());
      end
      if (got_ls) begin
         got_ls <= 1'b0;
         check({port.result_bus, ls}, wire_q.pop_front());
      end else if (b1 && !b2 && wire_q.size() > 0) begin
         ls <= port.result_bus;
         got_ls <= 1'b1;
      end
   end
   // expected result from the operand layout of each load format
   function automatic logic [63:0] expect_res(input logic [7:0] cmd,
      input logic [63:0] a, input logic [63:0] b);
      logic [63:0] x, y, r;
      x = {32'h0, a[31:0]};
      y = 64'h0;
      if (cmd[2:0] == FMT_TWO_SINGLES) begin
         y = {32'h0, b[31:0]};
      end
      if (cmd[2:0] == FMT_TWO_DOUBLES) begin
         x = a;
         y = b;
      end
      if (cmd[2:0] == FMT_ONE_LONG || cmd[2:0] == FMT_ONE_DOUBLE) begin
         x = a;
      end
      r = cmd[6:4] == KIND_ADD ? x + y : cmd[6:4] == KIND_SUB ? x - y : x;
      expect_res = cmd[OP_WIDE_BIT] ? r : {32'h0, r[31:0]};
   endfunction
   // one command: optional hold or kill a few cycles in
   task automatic run_op(input logic [2:0] kind, input logic [2:0] fmt,
      input logic wd, input int hl, input logic kl);
      logic [63:0] a, b, r;
      int n;
      a = {$urandom, $urandom};
      b = {$urandom, $urandom};
      r = expect_res({wd, kind, 1'b0, fmt}, a, b);
      for (n = 0; n < 60 && req_ready !== 1'b1; n++) @(posedge clk);
      req_valid <= 1'b1;
      req_cmd <= {wd, kind, 1'b0, fmt};
      req_a <= a;
      req_b <= b;
      if (!kl) begin
         exp_q.push_back(r);
         wire_q.push_back(wd ? r : {r[31:0], r[31:0]});
      end
      @(posedge clk);
      req_valid <= 1'b0;
      repeat (3) @(posedge clk);
      req_kill <= kl;
      req_hold <= hl > 0;
      repeat (hl + 1) @(posedge clk);
      req_kill <= 1'b0;
      req_hold <= 1'b0;
      for (n = 0; n < 60 && exp_q.size() > 0; n++) @(posedge clk);
      repeat (4) @(posedge clk);
      if (kl) check({63'h0, port.busy_n}, 64'h1);
   endtask
   initial begin
      logic [2:0] k, f;
      void'($urandom(32'h97db));
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      check({63'h0, rom_enable}, 64'h1);
      req_pwrdn <= 1'b1;
      repeat (3) @(posedge clk);
      check({63'h0, rom_enable}, 64'h0);
      req_pwrdn <= 1'b0;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 18; i++) begin
         k = 3'(i % 3);
         f = 3'(i % 6);
         run_op(k, f, 1'($urandom_range(1)), (i % 5 == 4) ? 4 : 0,
            i % 5 == 0 && i > 0);
      end
      repeat (10) @(posedge clk);
      check(64'(stalls), 64'(ops));
      test_done();
   end
endmodule
